// >>> design/ovl_cfg_pkg.sv
package ovl_cfg_pkg;

  // Register byte addresses.
  localparam logic [11:0] START_OFS  = 12'h2B0;
  localparam logic [11:0] END_OFS    = 12'h2B4;
  localparam logic [11:0] FETCH_OFS  = 12'h2B8;
  localparam logic [11:0] ZOOM_OFS   = 12'h2BC;
  localparam logic [11:0] MINIFY_OFS = 12'h2C0;
  localparam logic [11:0] CSC1_OFS   = 12'h2C4;
  localparam logic [11:0] CSC2_OFS   = 12'h2C8;
  localparam logic [11:0] BUFSEL_OFS = 12'h298;

  // Field positions and widths.
  localparam int POS_W     = 11;
  localparam int X_LSB     = 16;
  localparam int Y_LSB     = 0;
  localparam int FETCH_W   = 10;
  localparam int FWIN_LSB  = 20;
  localparam int FALP_LSB  = 0;
  localparam int HZEN_BIT  = 31;
  localparam int HZF_LSB   = 16;
  localparam int HZF_W     = 11;
  localparam int VZEN_BIT  = 15;
  localparam int VZF_LSB   = 0;
  localparam int VZF_W     = 10;
  localparam int MIN_W     = 3;
  localparam int HMIN_LSB  = 24;
  localparam int VMIN_LSB  = 16;
  localparam int CHR_BIT   = 2;
  localparam int HINT_BIT  = 1;
  localparam int VINT_BIT  = 0;
  localparam int SD_BIT    = 31;
  localparam int HD_BIT    = 30;
  localparam int A_LSB     = 24;
  localparam int RCB_LSB   = 16;
  localparam int RCR_LSB   = 8;
  localparam int DHI_LSB   = 0;
  localparam int DLO_LSB   = 29;
  localparam int GCB_LSB   = 24;
  localparam int GCR_LSB   = 16;
  localparam int BCB_LSB   = 8;
  localparam int BCR_LSB   = 0;
  localparam int BSEL_LSB  = 24;

  // Reset values.
  localparam logic [1:0] BSEL_RST = 2'h3;
  localparam logic [2:0] MIN_NONE = 3'h0;

  typedef struct packed {
    logic [4:0]  a;
    logic [5:0]  rcb;
    logic [5:0]  rcr;
    logic [4:0]  gcb;
    logic [4:0]  gcr;
    logic [5:0]  bcb;
    logic [5:0]  bcr;
    logic [10:0] d;
  } coef_t;

  // Preset matrices in register field format.
  localparam coef_t SD_COEF = '{a: 5'h13, rcb: 6'h00, rcr: 6'h0D, gcb: 5'h13,
                                gcr: 5'h17, bcb: 6'h08, bcr: 6'h00, d: 11'h780};
  localparam coef_t HD_COEF = '{a: 5'h13, rcb: 6'h00, rcr: 6'h0F, gcb: 5'h12,
                                gcr: 5'h14, bcb: 6'h09, bcr: 6'h00, d: 11'h780};

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
  } pix_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_t;

  typedef struct packed {
    logic [POS_W-1:0]   start_x;
    logic [POS_W-1:0]   start_y;
    logic [POS_W-1:0]   end_x;
    logic [POS_W-1:0]   end_y;
    logic [FETCH_W-1:0] fetch_win;
    logic [FETCH_W-1:0] fetch_alpha;
    logic               hz_en;
    logic [HZF_W-1:0]   hz_f;
    logic               vz_en;
    logic [VZF_W-1:0]   vz_f;
    logic [MIN_W-1:0]   hmin;
    logic [MIN_W-1:0]   vmin;
    logic               chroma_interp;
    logic               h_interp;
    logic               v_interp;
    logic               sd_en;
    logic               hd_en;
    coef_t              coef;
    logic [1:0]         bsel;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } state_t;

  typedef struct packed {
    logic [2:0] shift;
    logic       reserved;
  } ratio_t;

endpackage : ovl_cfg_pkg

// >>> design/minify_ratio.sv
`timescale 1ns/1ps
`default_nettype none
module minify_ratio (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [2:0]             code,
  output ovl_cfg_pkg::ratio_t         ratio_q
);

  ovl_cfg_pkg::ratio_t ratio_d;

  // Returns the power of two of the reduction, or flags the code.
  function automatic ovl_cfg_pkg::ratio_t decode(input logic [2:0] c);
    ovl_cfg_pkg::ratio_t r;
    r = '{shift: 3'h0, reserved: 1'b0};
    case (c)
      3'h0: r.shift = 3'h0;
      3'h1: r.shift = 3'h1;
      3'h3: r.shift = 3'h2;
      3'h5: r.shift = 3'h3;
      3'h7: r.shift = 3'h4;
      default: r.reserved = 1'b1;
    endcase
    return r;
  endfunction : decode

  always_comb begin
    ratio_d = decode(code);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_q <= '0;
    end else begin
      ratio_q <= ratio_d;
    end
  end

endmodule : minify_ratio
`default_nettype wire

// >>> design/csc_matrix.sv
`timescale 1ns/1ps
`default_nettype none
module csc_matrix (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire ovl_cfg_pkg::coef_t  coef,
  input  wire ovl_cfg_pkg::pix_t   pix,
  input  wire logic                pix_valid,
  output ovl_cfg_pkg::rgb_t        rgb_q,
  output logic                     rgb_valid_q
);

  typedef struct packed {
    ovl_cfg_pkg::rgb_t rgb;
    logic              valid;
  } cs_t;

  cs_t cs_q;
  cs_t cs_d;

  // Sign-magnitude coefficient times signed chroma, in 1/16 units.
  function automatic logic signed [20:0] smul(input logic sgn, input logic [4:0] mag,
                                              input logic signed [8:0] c,
                                              input logic [1:0] shl);
    logic signed [20:0] p;
    p = 21'(signed'({1'b0, mag}) * c) <<< shl;
    return sgn ? -p : p;
  endfunction : smul

  function automatic logic [7:0] clamp(input logic signed [20:0] s);
    logic signed [20:0] v;
    v = s >>> 4;
    if (v < 0) begin
      return 8'h00;
    end else if (v > 21'sd255) begin
      return 8'hFF;
    end
    return v[7:0];
  endfunction : clamp

  logic signed [8:0]  cb_s;
  logic signed [8:0]  cr_s;
  logic signed [20:0] luma;
  logic signed [20:0] off;

  always_comb begin
    cb_s = signed'({1'b0, pix.cb}) - 9'sd128;
    cr_s = signed'({1'b0, pix.cr}) - 9'sd128;
    // A has four fraction bits and is already in 1/16 units.
    luma = 21'(signed'({1'b0, coef.a}) * signed'({1'b0, pix.y}));
    off  = 21'(signed'(coef.d)) <<< 1;
    cs_d = cs_q;
    cs_d.valid = pix_valid;
    if (pix_valid) begin
      cs_d.rgb.r = clamp(luma + smul(coef.rcb[5], coef.rcb[4:0], cb_s, 2'h1)
                   + smul(coef.rcr[5], coef.rcr[4:0], cr_s, 2'h1) + off);
      cs_d.rgb.g = clamp(luma + smul(coef.gcb[4], {1'b0, coef.gcb[3:0]}, cb_s, 2'h1)
                   + smul(coef.gcr[4], {1'b0, coef.gcr[3:0]}, cr_s, 2'h1) + off);
      cs_d.rgb.b = clamp(luma + smul(coef.bcb[5], coef.bcb[4:0], cb_s, 2'h2)
                   + smul(coef.bcr[5], coef.bcr[4:0], cr_s, 2'h1) + off);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= '0;
    end else begin
      cs_q <= cs_d;
    end
  end

  assign rgb_q       = cs_q.rgb;
  assign rgb_valid_q = cs_q.valid;

endmodule : csc_matrix
`default_nettype wire

// >>> design/overlay_window_scaler_csc_regs.sv
// Operation
// - Start register: horizontal start 26:16 in pixels, vertical start 10:0 in lines.
// - End register: horizontal end 26:16 in pixels, vertical end 10:0 in lines.
// - Window per-line fetch count comes from fetch register bits 29:20.
// - Alpha window per-line fetch count comes from fetch register bits 9:0.
// - Horizontal zoom applies only when bit 31 set; factor in 26:16.
// - Vertical zoom applies only when bit 15 set; factor in 9:0.
// - Horizontal minify 26:24: 000 none, 001/011/101/111 by 2/4/8/16.
// - Vertical minify 18:16 uses the same codes; others reserved.
// - Bit 2 chooses luma-only or all-component vertical interpolation.
// - Bit 1 chooses horizontal replication or interpolation.
// - Bit 0 chooses vertical replication or interpolation.
// - Conversion bit 31 picks standard preset, bit 30 high-definition preset.
// - Coefficient A is unsigned 1.4 in bits 28:24.
// - Red chroma coefficients are 6-bit sign-magnitude 2.3 values.
// - Offset D is 11-bit two's complement split over both registers.
// - Green chroma coefficients are 5-bit sign-magnitude 1.3 values.
// - Blue Cb coefficient is 6-bit sign-magnitude with two fraction bits.
// - Blue Cr coefficient is 6-bit sign-magnitude in bits 5:0.
// - Red is A times Y plus Cb and Cr terms plus D.
// - Green and blue use their own coefficients in the same form.
// - Two-bit interpolation buffer select, resets to 11.
`timescale 1ns/1ps
`default_nettype none
module overlay_window_scaler_csc_regs (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  output logic [10:0]               win_start_x,
  output logic [10:0]               win_start_y,
  output logic [10:0]               win_end_x,
  output logic [10:0]               win_end_y,
  output logic [9:0]                win_fetch_count,
  output logic [9:0]                alpha_fetch_count,
  output logic                      h_zoom_en,
  output logic [10:0]               h_zoom_factor,
  output logic                      v_zoom_en,
  output logic [9:0]                v_zoom_factor,
  output ovl_cfg_pkg::ratio_t       h_minify,
  output ovl_cfg_pkg::ratio_t       v_minify,
  output logic                      chroma_interp,
  output logic                      h_interp,
  output logic                      v_interp,
  output logic [1:0]                interp_buf_sel,
  input  wire ovl_cfg_pkg::pix_t    pix,
  input  wire logic                 pix_valid,
  output ovl_cfg_pkg::rgb_t         rgb,
  output logic                      rgb_valid
);

  ovl_cfg_pkg::state_t st_q;
  ovl_cfg_pkg::state_t st_d;
  ovl_cfg_pkg::coef_t  coef_eff;
  logic                acc;

  function automatic logic mapped(input logic [11:0] a);
    case (a)
      ovl_cfg_pkg::START_OFS,
      ovl_cfg_pkg::END_OFS,
      ovl_cfg_pkg::FETCH_OFS,
      ovl_cfg_pkg::ZOOM_OFS,
      ovl_cfg_pkg::MINIFY_OFS,
      ovl_cfg_pkg::CSC1_OFS,
      ovl_cfg_pkg::CSC2_OFS,
      ovl_cfg_pkg::BUFSEL_OFS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : mapped

  // Builds the read word; any bit not placed here reads as zero.
  function automatic logic [31:0] rd(input ovl_cfg_pkg::state_t s,
                                     input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      ovl_cfg_pkg::START_OFS: begin
        w[ovl_cfg_pkg::X_LSB +: ovl_cfg_pkg::POS_W] = s.start_x;
        w[ovl_cfg_pkg::Y_LSB +: ovl_cfg_pkg::POS_W] = s.start_y;
      end
      ovl_cfg_pkg::END_OFS: begin
        w[ovl_cfg_pkg::X_LSB +: ovl_cfg_pkg::POS_W] = s.end_x;
        w[ovl_cfg_pkg::Y_LSB +: ovl_cfg_pkg::POS_W] = s.end_y;
      end
      ovl_cfg_pkg::FETCH_OFS: begin
        w[ovl_cfg_pkg::FWIN_LSB +: ovl_cfg_pkg::FETCH_W] = s.fetch_win;
        w[ovl_cfg_pkg::FALP_LSB +: ovl_cfg_pkg::FETCH_W] = s.fetch_alpha;
      end
      ovl_cfg_pkg::ZOOM_OFS: begin
        w[ovl_cfg_pkg::HZEN_BIT] = s.hz_en;
        w[ovl_cfg_pkg::HZF_LSB +: ovl_cfg_pkg::HZF_W] = s.hz_f;
        w[ovl_cfg_pkg::VZEN_BIT] = s.vz_en;
        w[ovl_cfg_pkg::VZF_LSB +: ovl_cfg_pkg::VZF_W] = s.vz_f;
      end
      ovl_cfg_pkg::MINIFY_OFS: begin
        w[ovl_cfg_pkg::HMIN_LSB +: ovl_cfg_pkg::MIN_W] = s.hmin;
        w[ovl_cfg_pkg::VMIN_LSB +: ovl_cfg_pkg::MIN_W] = s.vmin;
        w[ovl_cfg_pkg::CHR_BIT] = s.chroma_interp;
        w[ovl_cfg_pkg::HINT_BIT] = s.h_interp;
        w[ovl_cfg_pkg::VINT_BIT] = s.v_interp;
      end
      ovl_cfg_pkg::CSC1_OFS: begin
        w[ovl_cfg_pkg::SD_BIT] = s.sd_en;
        w[ovl_cfg_pkg::HD_BIT] = s.hd_en;
        w[ovl_cfg_pkg::A_LSB +: 5] = s.coef.a;
        w[ovl_cfg_pkg::RCB_LSB +: 6] = s.coef.rcb;
        w[ovl_cfg_pkg::RCR_LSB +: 6] = s.coef.rcr;
        w[ovl_cfg_pkg::DHI_LSB +: 8] = s.coef.d[10:3];
      end
      ovl_cfg_pkg::CSC2_OFS: begin
        w[ovl_cfg_pkg::DLO_LSB +: 3] = s.coef.d[2:0];
        w[ovl_cfg_pkg::GCB_LSB +: 5] = s.coef.gcb;
        w[ovl_cfg_pkg::GCR_LSB +: 5] = s.coef.gcr;
        w[ovl_cfg_pkg::BCB_LSB +: 6] = s.coef.bcb;
        w[ovl_cfg_pkg::BCR_LSB +: 6] = s.coef.bcr;
      end
      ovl_cfg_pkg::BUFSEL_OFS: begin
        w[ovl_cfg_pkg::BSEL_LSB +: 2] = s.bsel;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : rd

  always_comb begin
    st_d = st_q;
    // The slave inserts one wait state so that pready and prdata
    // can both come straight from flip-flops.
    acc = psel && penable;
    st_d.pready  = acc && !st_q.pready;
    st_d.pslverr = 1'b0;
    if (acc && !st_q.pready) begin
      st_d.prdata  = rd(st_q, paddr);
      st_d.pslverr = !mapped(paddr);
    end
    // Writes land only on the completing edge; reserved bits are dropped.
    if (acc && st_q.pready && pwrite) begin
      case (paddr)
        ovl_cfg_pkg::START_OFS: begin
          st_d.start_x = pwdata[ovl_cfg_pkg::X_LSB +: ovl_cfg_pkg::POS_W];
          st_d.start_y = pwdata[ovl_cfg_pkg::Y_LSB +: ovl_cfg_pkg::POS_W];
        end
        ovl_cfg_pkg::END_OFS: begin
          st_d.end_x = pwdata[ovl_cfg_pkg::X_LSB +: ovl_cfg_pkg::POS_W];
          st_d.end_y = pwdata[ovl_cfg_pkg::Y_LSB +: ovl_cfg_pkg::POS_W];
        end
        ovl_cfg_pkg::FETCH_OFS: begin
          st_d.fetch_win   = pwdata[ovl_cfg_pkg::FWIN_LSB +: ovl_cfg_pkg::FETCH_W];
          st_d.fetch_alpha = pwdata[ovl_cfg_pkg::FALP_LSB +: ovl_cfg_pkg::FETCH_W];
        end
        ovl_cfg_pkg::ZOOM_OFS: begin
          st_d.hz_en = pwdata[ovl_cfg_pkg::HZEN_BIT];
          st_d.hz_f  = pwdata[ovl_cfg_pkg::HZF_LSB +: ovl_cfg_pkg::HZF_W];
          st_d.vz_en = pwdata[ovl_cfg_pkg::VZEN_BIT];
          st_d.vz_f  = pwdata[ovl_cfg_pkg::VZF_LSB +: ovl_cfg_pkg::VZF_W];
        end
        ovl_cfg_pkg::MINIFY_OFS: begin
          st_d.hmin = pwdata[ovl_cfg_pkg::HMIN_LSB +: ovl_cfg_pkg::MIN_W];
          st_d.vmin = pwdata[ovl_cfg_pkg::VMIN_LSB +: ovl_cfg_pkg::MIN_W];
          st_d.chroma_interp = pwdata[ovl_cfg_pkg::CHR_BIT];
          st_d.h_interp = pwdata[ovl_cfg_pkg::HINT_BIT];
          st_d.v_interp = pwdata[ovl_cfg_pkg::VINT_BIT];
        end
        ovl_cfg_pkg::CSC1_OFS: begin
          st_d.sd_en = pwdata[ovl_cfg_pkg::SD_BIT];
          st_d.hd_en = pwdata[ovl_cfg_pkg::HD_BIT];
          st_d.coef.a  = pwdata[ovl_cfg_pkg::A_LSB +: 5];
          st_d.coef.rcb = pwdata[ovl_cfg_pkg::RCB_LSB +: 6];
          st_d.coef.rcr = pwdata[ovl_cfg_pkg::RCR_LSB +: 6];
          st_d.coef.d[10:3] = pwdata[ovl_cfg_pkg::DHI_LSB +: 8];
        end
        ovl_cfg_pkg::CSC2_OFS: begin
          st_d.coef.d[2:0] = pwdata[ovl_cfg_pkg::DLO_LSB +: 3];
          st_d.coef.gcb = pwdata[ovl_cfg_pkg::GCB_LSB +: 5];
          st_d.coef.gcr = pwdata[ovl_cfg_pkg::GCR_LSB +: 5];
          st_d.coef.bcb = pwdata[ovl_cfg_pkg::BCB_LSB +: 6];
          st_d.coef.bcr = pwdata[ovl_cfg_pkg::BCR_LSB +: 6];
        end
        ovl_cfg_pkg::BUFSEL_OFS: begin
          st_d.bsel = pwdata[ovl_cfg_pkg::BSEL_LSB +: 2];
        end
        default: st_d.bsel = st_q.bsel;
      endcase
    end
  end

  // A preset overrides the programmed matrix; standard wins if both are set.
  always_comb begin
    if (st_q.sd_en) begin
      coef_eff = ovl_cfg_pkg::SD_COEF;
    end else if (st_q.hd_en) begin
      coef_eff = ovl_cfg_pkg::HD_COEF;
    end else begin
      coef_eff = st_q.coef;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= '0;
      st_q.bsel <= ovl_cfg_pkg::BSEL_RST;
      st_q.hmin <= ovl_cfg_pkg::MIN_NONE;
      st_q.vmin <= ovl_cfg_pkg::MIN_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  minify_ratio u_hmin (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (st_q.hmin),
    .ratio_q (h_minify)
  );

  minify_ratio u_vmin (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (st_q.vmin),
    .ratio_q (v_minify)
  );

  csc_matrix u_csc (
    .pclk        (pclk),
    .presetn     (presetn),
    .coef        (coef_eff),
    .pix         (pix),
    .pix_valid   (pix_valid),
    .rgb_q       (rgb),
    .rgb_valid_q (rgb_valid)
  );

  // Interpolation on both overlay windows at large resolutions is
  // left to software; the select is passed through untouched.
  assign interp_buf_sel    = st_q.bsel;
  assign pready            = st_q.pready;
  assign prdata            = st_q.prdata;
  assign pslverr           = st_q.pslverr;
  assign win_start_x       = st_q.start_x;
  assign win_start_y       = st_q.start_y;
  assign win_end_x         = st_q.end_x;
  assign win_end_y         = st_q.end_y;
  assign win_fetch_count   = st_q.fetch_win;
  assign alpha_fetch_count = st_q.fetch_alpha;
  assign h_zoom_en         = st_q.hz_en;
  assign h_zoom_factor     = st_q.hz_f;
  assign v_zoom_en         = st_q.vz_en;
  assign v_zoom_factor     = st_q.vz_f;
  assign chroma_interp     = st_q.chroma_interp;
  assign h_interp          = st_q.h_interp;
  assign v_interp          = st_q.v_interp;

endmodule : overlay_window_scaler_csc_regs
`default_nettype wire

// >>> dv/ovl_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ovl_regs_chk (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [10:0]         win_start_x,
  input wire logic [10:0]         win_start_y,
  input wire logic [10:0]         win_end_x,
  input wire logic [10:0]         win_end_y,
  input wire logic [9:0]          win_fetch_count,
  input wire logic [9:0]          alpha_fetch_count,
  input wire logic                h_zoom_en,
  input wire logic [10:0]         h_zoom_factor,
  input wire logic                v_zoom_en,
  input wire logic [9:0]          v_zoom_factor,
  input wire ovl_cfg_pkg::ratio_t h_minify,
  input wire ovl_cfg_pkg::ratio_t v_minify,
  input wire logic                chroma_interp,
  input wire logic                h_interp,
  input wire logic                v_interp,
  input wire logic [1:0]          interp_buf_sel,
  input wire logic                pix_valid,
  input wire logic                rgb_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Write data one and two edges back, since outputs follow the write edge.
  logic [31:0] wd_q;
  logic [31:0] wd2_q;
  wire logic   wr_done = psel && penable && pwrite && pready;
  wire logic   mapped  = (paddr >= ovl_cfg_pkg::START_OFS && paddr <= ovl_cfg_pkg::CSC2_OFS
                          && paddr[1:0] == 2'h0) || paddr == ovl_cfg_pkg::BUFSEL_OFS;

  always_ff @(posedge pclk) begin
    wd_q  <= pwdata;
    wd2_q <= wd_q;
  end

  function automatic logic [3:0] dec(input logic [2:0] c);
    case (c)
      3'h0: dec = 4'h0;
      3'h1: dec = 4'h2;
      3'h3: dec = 4'h4;
      3'h5: dec = 4'h6;
      3'h7: dec = 4'h8;
      default: dec = 4'h1;
    endcase
  endfunction : dec

  start_pos_a: assert property (wr_done && paddr == ovl_cfg_pkg::START_OFS |=>
    {win_start_x, win_start_y} == {wd_q[26:16], wd_q[10:0]}) else $error("start position");
  end_pos_a: assert property (wr_done && paddr == ovl_cfg_pkg::END_OFS |=>
    {win_end_x, win_end_y} == {wd_q[26:16], wd_q[10:0]}) else $error("end position");
  fetch_cnt_a: assert property (wr_done && paddr == ovl_cfg_pkg::FETCH_OFS |=>
    {win_fetch_count, alpha_fetch_count} == {wd_q[29:20], wd_q[9:0]}) else $error("fetch");
  zoom_ctl_a: assert property (wr_done && paddr == ovl_cfg_pkg::ZOOM_OFS |=>
    {h_zoom_en, h_zoom_factor, v_zoom_en, v_zoom_factor}
    == {wd_q[31], wd_q[26:16], wd_q[15], wd_q[9:0]}) else $error("zoom");
  minify_dec_a: assert property (wr_done && paddr == ovl_cfg_pkg::MINIFY_OFS |=> ##1
    h_minify == dec(wd2_q[26:24]) && v_minify == dec(wd2_q[18:16])) else $error("minify");
  interp_sel_a: assert property (wr_done && paddr == ovl_cfg_pkg::MINIFY_OFS |=>
    {chroma_interp, h_interp, v_interp} == wd_q[2:0]) else $error("interp select");
  buf_rst_a: assert property ($rose(presetn) |-> interp_buf_sel == 2'h3) else $error("buf reset");
  unmapped_err_a: assert property (pready |-> pslverr == !mapped) else $error("slave error");
  rgb_valid_a: assert property (##1 rgb_valid == $past(pix_valid)) else $error("rgb valid");
endmodule : ovl_regs_chk

bind overlay_window_scaler_csc_regs ovl_regs_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .win_start_x, .win_start_y, .win_end_x,
  .win_end_y, .win_fetch_count, .alpha_fetch_count, .h_zoom_en, .h_zoom_factor, .v_zoom_en,
  .v_zoom_factor, .h_minify, .v_minify, .chroma_interp, .h_interp, .v_interp,
  .interp_buf_sel, .pix_valid, .rgb_valid);
`default_nettype wire

// >>> dv/test_overlay_window_scaler_csc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_overlay_window_scaler_csc_regs;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, pix_valid;
  logic               h_zoom_en, v_zoom_en, chroma_interp, h_interp, v_interp, rgb_valid;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic [10:0]        win_start_x, win_start_y, win_end_x, win_end_y, h_zoom_factor;
  logic [9:0]         win_fetch_count, alpha_fetch_count, v_zoom_factor;
  logic [1:0]         interp_buf_sel;
  ovl_cfg_pkg::ratio_t h_minify, v_minify;
  ovl_cfg_pkg::pix_t  pix;
  ovl_cfg_pkg::rgb_t  rgb;
  int                 miscompares = 0;
  int                 n_checks = 0;
  localparam logic [11:0] ADR [8] = '{ovl_cfg_pkg::START_OFS, ovl_cfg_pkg::END_OFS,
    ovl_cfg_pkg::FETCH_OFS, ovl_cfg_pkg::ZOOM_OFS, ovl_cfg_pkg::MINIFY_OFS,
    ovl_cfg_pkg::CSC1_OFS, ovl_cfg_pkg::CSC2_OFS, ovl_cfg_pkg::BUFSEL_OFS};
  localparam logic [31:0] MSK [8] = '{32'h07FF07FF, 32'h07FF07FF, 32'h3FF003FF, 32'h87FF83FF,
    32'h07070007, 32'hDF3F3FFF, 32'hFF1F3F3F, 32'h03000000};
  localparam logic [3:0] MIN [8] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h1, 4'h6, 4'h1, 4'h8};
  localparam ovl_cfg_pkg::coef_t K = '{a: 5'h10, rcb: 6'h21, rcr: 6'h0C, gcb: 5'h12,
                                       gcr: 5'h03, bcb: 6'h05, bcr: 6'h23, d: 11'h7F0};

  overlay_window_scaler_csc_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .win_start_x, .win_start_y, .win_end_x, .win_end_y,
    .win_fetch_count, .alpha_fetch_count, .h_zoom_en, .h_zoom_factor, .v_zoom_en,
    .v_zoom_factor, .h_minify, .v_minify, .chroma_interp, .h_interp, .v_interp,
    .interp_buf_sel, .pix, .pix_valid, .rgb, .rgb_valid);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Starts on an edge, so one idle cycle always separates two transfers.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check("read data", exp, r);
    check("read error", {31'h0, xe}, {31'h0, e});
  endtask : rd

  function automatic int sm(input logic s, input logic [4:0] m);
    return s ? -int'(m) : int'(m);
  endfunction : sm

  function automatic logic [7:0] chan(input int a, b, c, d, s, y, cb, cr);
    int v;
    v = (a * y + b * (cb - 128) * s + c * (cr - 128) * 2 + 2 * d) >>> 4;
    if (v < 0) return 8'h00;
    if (v > 255) return 8'hFF;
    return v[7:0];
  endfunction : chan

  function automatic ovl_cfg_pkg::rgb_t model(input ovl_cfg_pkg::coef_t k,
                                              input ovl_cfg_pkg::pix_t p);
    int a, d, y, cb, cr;
    a = int'(k.a);
    d = int'($signed(k.d));
    y = int'(p.y);
    cb = int'(p.cb);
    cr = int'(p.cr);
    model.r = chan(a, sm(k.rcb[5], k.rcb[4:0]), sm(k.rcr[5], k.rcr[4:0]), d, 2, y, cb, cr);
    model.g = chan(a, sm(k.gcb[4], {1'b0, k.gcb[3:0]}), sm(k.gcr[4], {1'b0, k.gcr[3:0]}), d, 2,
                   y, cb, cr);
    model.b = chan(a, sm(k.bcb[5], k.bcb[4:0]), sm(k.bcr[5], k.bcr[4:0]), d, 4, y, cb, cr);
  endfunction : model

  task automatic test_reset;
    for (int i = 0; i < 8; i++) rd(ADR[i], (i == 7) ? MSK[7] : 32'h0, 1'b0);
    check("buffer select", 32'h3, {30'h0, interp_buf_sel});
    check("window", 32'h0, {win_start_x, win_end_x, win_fetch_count});
    check("modes", 32'h0, {h_minify, v_minify, h_zoom_en, v_zoom_en, v_interp});
  endtask : test_reset

  task automatic test_masks;
    for (int i = 0; i < 8; i++) begin
      wr(ADR[i], 32'hFFFFFFFF);
      rd(ADR[i], MSK[i], 1'b0);
      wr(ADR[i], 32'hA5A5A5A5);
      rd(ADR[i], MSK[i] & 32'hA5A5A5A5, 1'b0);
    end
  endtask : test_masks

  task automatic test_fields;
    wr(ovl_cfg_pkg::START_OFS, 32'h01230456);
    wr(ovl_cfg_pkg::END_OFS, 32'h07FF0001);
    wr(ovl_cfg_pkg::FETCH_OFS, 32'h2AB00155);
    wr(ovl_cfg_pkg::ZOOM_OFS, 32'h855582AA);
    @(negedge pclk);
    check("start", 32'h01230456, {5'h0, win_start_x, 5'h0, win_start_y});
    check("end", 32'h07FF0001, {5'h0, win_end_x, 5'h0, win_end_y});
    check("fetch", 32'h2AB00155, {2'h0, win_fetch_count, 10'h0, alpha_fetch_count});
    check("zoom", 32'h855582AA, {h_zoom_en, 4'h0, h_zoom_factor, v_zoom_en, 5'h0,
                                 v_zoom_factor});
    wr(ovl_cfg_pkg::ZOOM_OFS, 32'h055502AA);
    @(negedge pclk);
    check("zoom off", 32'h2AA, {h_zoom_en, v_zoom_en, 20'h0, v_zoom_factor});
  endtask : test_fields

  task automatic test_minify;
    for (int c = 0; c < 8; c++) begin
      wr(ovl_cfg_pkg::MINIFY_OFS, {5'h0, c[2:0], 5'h0, ~c[2:0], 13'h0, c[2:0]});
      repeat (2) @(negedge pclk);
      check("minify", {24'h0, MIN[c], MIN[7 - c]}, {24'h0, h_minify, v_minify});
      check("interp", c, {29'h0, chroma_interp, h_interp, v_interp});
    end
  endtask : test_minify

  task automatic test_unmapped;
    wr(12'h2CC, 32'hFFFFFFFF);
    rd(12'h2CC, 32'h0, 1'b1);
    rd(ovl_cfg_pkg::START_OFS, 32'h01230456, 1'b0);
  endtask : test_unmapped

  task automatic csc(input logic [1:0] pre, input ovl_cfg_pkg::pix_t p,
                     input ovl_cfg_pkg::coef_t u);
    wr(ovl_cfg_pkg::CSC1_OFS, {pre, 1'b0, K.a, 2'h0, K.rcb, 2'h0, K.rcr, K.d[10:3]});
    wr(ovl_cfg_pkg::CSC2_OFS, {K.d[2:0], K.gcb, 3'h0, K.gcr, 2'h0, K.bcb, 2'h0, K.bcr});
    @(posedge pclk);
    pix <= p;
    pix_valid <= 1'b1;
    @(posedge pclk);
    pix_valid <= 1'b0;
    @(negedge pclk);
    check("rgb valid", 32'h1, {31'h0, rgb_valid});
    check("rgb", {8'h0, model(u, p)}, {8'h0, rgb});
  endtask : csc

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pix = '0;
    pix_valid = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_masks();
    test_fields();
    test_minify();
    test_unmapped();
    csc(2'h0, 24'h80A060, K);
    csc(2'h0, 24'h00FF00, K);
    csc(2'h0, 24'hFF00FF, K);
    csc(2'h2, 24'h80A060, ovl_cfg_pkg::SD_COEF);
    csc(2'h1, 24'h80A060, ovl_cfg_pkg::HD_COEF);
    csc(2'h3, 24'h80A060, ovl_cfg_pkg::SD_COEF);
    print_verdict();
  end
endmodule : test_overlay_window_scaler_csc_regs
`default_nettype wire
